/* File: inc/fsps_pkg.sv */
// constants, types and layouts for the flash self-program sequencer
// assumes one 125 MHz system clock and a 32-bit Avalon-MM register bus
package fsps_pkg;
    // timing
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam real         PROG_MIN_MS   = 3.7;
    localparam real         PROG_MAX_MS   = 4.5;
    localparam int unsigned PROG_MIN_CYC  = int'($ceil(PROG_MIN_MS * CLK_HZ / 1000.0));
    localparam int unsigned PROG_MAX_CYC  = int'($floor(PROG_MAX_MS * CLK_HZ / 1000.0));
    localparam int unsigned ARM_W         = 3;
    localparam logic [2:0]  STORE_WIN     = 3'h4;
    localparam logic [2:0]  LOAD_WIN      = 3'h3;
    localparam logic [2:0]  ARM_LAST      = 3'h1;
    // register byte offsets
    localparam logic [4:0]  OFS_CTRL      = 5'h00;
    localparam logic [4:0]  OFS_PTR       = 5'h04;
    localparam logic [4:0]  OFS_DATA      = 5'h08;
    localparam logic [4:0]  OFS_STORE     = 5'h0C;
    localparam logic [4:0]  OFS_LOAD      = 5'h10;
    // control register fields
    localparam int unsigned CMD_W         = 5;
    localparam int unsigned BIT_EN        = 0;
    localparam int unsigned BIT_BUSY      = 6;
    localparam int unsigned BIT_IE        = 7;
    localparam logic [4:0]  CMD_NONE      = 5'h00;
    localparam logic [4:0]  CMD_BUF_LOAD  = 5'h01;
    localparam logic [4:0]  CMD_ERASE     = 5'h03;
    localparam logic [4:0]  CMD_WRITE     = 5'h05;
    localparam logic [4:0]  CMD_LOCK      = 5'h09;
    localparam logic [4:0]  CMD_READ_EN   = 5'h11;
    // pointer layout
    localparam int unsigned PAGE_W        = 7;
    localparam int unsigned PAGE_LSB      = 6;
    localparam int unsigned WORD_W        = 5;
    localparam int unsigned WORD_LSB      = 1;
    localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] PTR_LOCK      = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT  = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
    // lock and fuse values
    localparam int unsigned LOCK_LSB      = 2;
    localparam int unsigned LOCK_W        = 4;
    localparam logic [7:0]  LOCK_RST      = 8'hFF;
    localparam logic [3:0]  EXT_PAD       = 4'hF;
    localparam logic [7:0]  BLOCKED_BYTE  = 8'hFF;
    localparam logic [31:0] UNMAPPED      = 32'h0000_0000;

    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_ERASE = 2'b01,
        OP_WRITE = 2'b11,
        OP_LOCK  = 2'b10
    } fsps_op_e;

    typedef struct packed {
        logic              erase;
        logic              write;
        logic              buf_load;
        logic              buf_clear;
        logic [PAGE_W-1:0] page;
        logic [WORD_W-1:0] word;
        logic [15:0]       data;
    } fsps_flash_s;
endpackage

/* File: rtl/fsps_prog_timer.sv */
// programming timer: holds one erase, write or lock operation for its full time
// reset only by power-on reset so a system reset cannot cut an operation short
`timescale 1ns/1ns
module fsps_prog_timer #(
    parameter int unsigned CYCLES = fsps_pkg::PROG_MIN_CYC
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_por,
    input  wire logic                        i_start,
    input  wire fsps_pkg::fsps_op_e          i_kind,
    input  wire logic [fsps_pkg::PAGE_W-1:0] i_page,
    input  wire logic [fsps_pkg::LOCK_W-1:0] i_lock,
    output logic                             o_busy,
    output logic                             o_done,
    output logic                             o_erase,
    output logic                             o_write,
    output fsps_pkg::fsps_op_e               o_kind,
    output logic [fsps_pkg::PAGE_W-1:0]      o_page,
    output logic [fsps_pkg::LOCK_W-1:0]      o_lock
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_reg;
    wire           last = o_busy && (cnt_reg == CW'(1));

    always_ff @(posedge i_clk or posedge i_por) begin
        if (i_por) begin
            cnt_reg <= '0;
            o_busy  <= 1'b0;
            o_done  <= 1'b0;
            o_erase <= 1'b0;
            o_write <= 1'b0;
            o_kind  <= fsps_pkg::OP_IDLE;
            o_page  <= '0;
            o_lock  <= '1;
        end else begin
            o_done <= last;
            if (i_start && !o_busy) begin
                cnt_reg <= CW'(CYCLES);
                o_busy  <= 1'b1;
                o_erase <= (i_kind == fsps_pkg::OP_ERASE);
                o_write <= (i_kind == fsps_pkg::OP_WRITE);
                o_kind  <= i_kind;
                o_page  <= i_page;
                o_lock  <= i_lock;
            end else if (last) begin
                cnt_reg <= '0;
                o_busy  <= 1'b0;
                o_erase <= 1'b0;
                o_write <= 1'b0;
            end else if (o_busy) begin
                cnt_reg <= cnt_reg - CW'(1);
            end
        end
    end
endmodule

/* File: rtl/fsps_sequencer.sv */
// flash self-program sequencer: control register, store and load hooks, lock/fuse read
// assumes an Avalon-MM master standing in for the core, an eeprom busy level,
// and a flash array that returns the byte at o_mem_addr on i_mem_rdata in the same cycle
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
module fsps_sequencer #(
    parameter int unsigned                  PROG_CYCLES     = fsps_pkg::PROG_MIN_CYC,
    parameter logic [fsps_pkg::PAGE_W-1:0]  HALT_FIRST_PAGE = 7'h60,
    parameter logic [7:0]                   FUSE_LOW        = 8'hFF,
    parameter logic [7:0]                   FUSE_HIGH       = 8'hFF,
    parameter logic [3:0]                   FUSE_EXT        = 4'hF
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_por,
    input  wire logic [4:0]            i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [31:0]           i_avs_writedata,
    input  wire logic [3:0]            i_avs_byteenable,
    output logic [31:0]                o_avs_readdata,
    output logic                       o_avs_waitrequest,
    input  wire logic                  i_eeprom_busy,
    input  wire logic [7:0]            i_mem_rdata,
    output logic [15:0]                o_mem_addr,
    output fsps_pkg::fsps_flash_s      o_flash,
    output logic                       o_section_blocked,
    output logic                       o_cpu_halt,
    output logic                       o_irq
);
    // register state
    logic [fsps_pkg::CMD_W-1:0] cmd_reg;
    logic [fsps_pkg::CMD_W-1:0] cmd_next;
    logic [fsps_pkg::ARM_W-1:0] arm_reg;
    logic [fsps_pkg::ARM_W-1:0] arm_next;
    logic                       ie_reg;
    logic [15:0]                ptr_reg;
    logic [15:0]                dat_reg;
    logic [7:0]                 lock_reg;
    logic                       busy_flag_reg;
    logic                       busy_flag_next;
    logic                       wait_reg;
    logic [31:0]                rdata_reg;
    logic [31:0]                rd_word;
    logic [7:0]                 load_byte;
    logic                       halt_reg;
    logic                       irq_reg;
    logic                       buf_load_reg;
    logic                       buf_clear_reg;
    logic [fsps_pkg::WORD_W-1:0] word_reg;
    logic [15:0]                data_reg;

    // timer outputs
    logic                        op_busy;
    logic                        op_done;
    logic                        op_erase;
    logic                        op_write;
    fsps_pkg::fsps_op_e          op_kind;
    logic [fsps_pkg::PAGE_W-1:0] op_page;
    logic [fsps_pkg::LOCK_W-1:0] op_lock;

    // bus handshake: one wait cycle, then waitrequest low for exactly one edge
    wire req     = i_avs_read || i_avs_write;
    wire acc     = req && !wait_reg;
    wire rd_take = i_avs_read && wait_reg && !halt_reg;
    wire wr_acc  = acc && i_avs_write;

    // address decode
    wire a_ctrl  = (i_avs_address == fsps_pkg::OFS_CTRL);
    wire a_ptr   = (i_avs_address == fsps_pkg::OFS_PTR);
    wire a_data  = (i_avs_address == fsps_pkg::OFS_DATA);
    wire a_store = (i_avs_address == fsps_pkg::OFS_STORE);
    wire a_load  = (i_avs_address == fsps_pkg::OFS_LOAD);

    // command pattern check on the low five control bits
    wire [fsps_pkg::CMD_W-1:0] wr_cmd = i_avs_writedata[fsps_pkg::CMD_W-1:0];
    wire cmd_valid = (wr_cmd == fsps_pkg::CMD_BUF_LOAD) || (wr_cmd == fsps_pkg::CMD_ERASE) ||
                     (wr_cmd == fsps_pkg::CMD_WRITE) || (wr_cmd == fsps_pkg::CMD_LOCK) ||
                     (wr_cmd == fsps_pkg::CMD_READ_EN);
    wire ctrl_wr   = wr_acc && a_ctrl && i_avs_byteenable[0];
    wire ctrl_take = ctrl_wr && !i_eeprom_busy && !op_busy;

    // store is honoured only while armed, idle and no eeprom write runs
    // no store outside window
    wire armed     = (arm_reg != '0);
    wire st_take   = wr_acc && a_store && armed && !op_busy && !i_eeprom_busy;
    wire st_bload  = st_take && (cmd_reg == fsps_pkg::CMD_BUF_LOAD);
    wire st_erase  = st_take && (cmd_reg == fsps_pkg::CMD_ERASE);
    wire st_write  = st_take && (cmd_reg == fsps_pkg::CMD_WRITE);
    wire st_lock   = st_take && (cmd_reg == fsps_pkg::CMD_LOCK);
    wire st_rden   = st_take && (cmd_reg == fsps_pkg::CMD_READ_EN);
    wire st_long   = st_erase || st_write || st_lock;

    // pointer fields
    wire [fsps_pkg::PAGE_W-1:0] ptr_page = ptr_reg[fsps_pkg::PAGE_LSB +: fsps_pkg::PAGE_W];
    wire [fsps_pkg::WORD_W-1:0] ptr_word = ptr_reg[fsps_pkg::WORD_LSB +: fsps_pkg::WORD_W];
    wire ptr_concurrent = (ptr_page < HALT_FIRST_PAGE);
    wire op_concurrent  = (op_page < HALT_FIRST_PAGE);

    wire special_arm = (cmd_reg == fsps_pkg::CMD_LOCK) && (arm_reg > (fsps_pkg::STORE_WIN - fsps_pkg::LOAD_WIN));
    wire ld_special  = rd_take && a_load && special_arm && !op_busy;

    wire en_read = cmd_reg[fsps_pkg::BIT_EN] || op_busy;

    wire halt_next = (op_erase || op_write) && !op_concurrent;

    wire irq_next = ie_reg && !en_read;

    // buffer erase after write or read enable
    wire clear_next = st_rden || (op_done && (op_kind == fsps_pkg::OP_WRITE));

    // the lock and fuse pointers select fixed bytes; any other pointer reads as unprogrammed
    // normal load otherwise; 0xFF while busy flag set and pointer in concurrent section
    always_comb begin
        load_byte = i_mem_rdata;
        if (special_arm && !op_busy) begin
            if (i_eeprom_busy) begin
                load_byte = fsps_pkg::BLOCKED_BYTE;
            end else if (ptr_reg == fsps_pkg::PTR_LOCK) begin
                load_byte = lock_reg;
            end else if (ptr_reg == fsps_pkg::PTR_FUSE_LOW) begin
                load_byte = FUSE_LOW;
            end else if (ptr_reg == fsps_pkg::PTR_FUSE_HIGH) begin
                load_byte = FUSE_HIGH;
            end else if (ptr_reg == fsps_pkg::PTR_FUSE_EXT) begin
                load_byte = {fsps_pkg::EXT_PAD, FUSE_EXT};
            end else begin
                load_byte = fsps_pkg::BLOCKED_BYTE;
            end
        end else if (busy_flag_reg && ptr_concurrent) begin
            load_byte = fsps_pkg::BLOCKED_BYTE;
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb begin
        rd_word = fsps_pkg::UNMAPPED;
        if (a_ctrl) begin
            rd_word = {24'h000000, ie_reg, busy_flag_reg, 1'b0, cmd_reg[4:1], en_read};
        end else if (a_ptr) begin
            rd_word = {16'h0000, ptr_reg};
        end else if (a_data) begin
            rd_word = {16'h0000, dat_reg};
        end else if (a_store) begin
            rd_word = {29'h00000000, i_eeprom_busy, halt_reg, busy_flag_reg};
        end else if (a_load) begin
            rd_word = {24'h000000, load_byte};
        end
    end

    // command and arming window, later lines take priority
    always_comb begin
        cmd_next = cmd_reg;
        arm_next = armed ? (arm_reg - fsps_pkg::ARM_W'(1)) : arm_reg;
        if (op_done) begin
            cmd_next = fsps_pkg::CMD_NONE;
        end
        if ((arm_reg == fsps_pkg::ARM_LAST) && !op_busy) begin
            cmd_next = fsps_pkg::CMD_NONE;
        end
        // clear on completion, hold during operation
        if (st_take) begin
            arm_next = '0;
            cmd_next = st_long ? cmd_reg : fsps_pkg::CMD_NONE;
        end
        if (ld_special) begin
            arm_next = '0;
            cmd_next = fsps_pkg::CMD_NONE;
        end
        if (ctrl_take) begin
            arm_next = cmd_valid ? fsps_pkg::STORE_WIN : fsps_pkg::ARM_W'(0);
            cmd_next = cmd_valid ? wr_cmd : fsps_pkg::CMD_NONE;
        end
    end

    // busy flag set by erase/write to the concurrent section, cleared by read enable
    always_comb begin
        busy_flag_next = busy_flag_reg;
        if (st_rden) begin
            busy_flag_next = 1'b0;
        end
        if ((st_erase || st_write) && ptr_concurrent) begin
            busy_flag_next = 1'b1;
        end
    end

    // control register and arming
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cmd_reg <= fsps_pkg::CMD_NONE;
            arm_reg <= '0;
            ie_reg  <= 1'b0;
        end else begin
            cmd_reg <= cmd_next;
            arm_reg <= arm_next;
            if (ctrl_wr) begin
                ie_reg <= i_avs_writedata[fsps_pkg::BIT_IE];
            end
        end
    end

    // pointer and working registers, byte lanes honoured
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ptr_reg <= 16'h0000;
            dat_reg <= 16'h0000;
        end else begin
            if (wr_acc && a_ptr && i_avs_byteenable[0]) ptr_reg[7:0]  <= i_avs_writedata[7:0];
            if (wr_acc && a_ptr && i_avs_byteenable[1]) ptr_reg[15:8] <= i_avs_writedata[15:8];
            if (wr_acc && a_data && i_avs_byteenable[0]) dat_reg[7:0]  <= i_avs_writedata[7:0];
            if (wr_acc && a_data && i_avs_byteenable[1]) dat_reg[15:8] <= i_avs_writedata[15:8];
        end
    end

    // bus answer: waitrequest held high while the core is halted
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_reg  <= 1'b1;
            rdata_reg <= fsps_pkg::UNMAPPED;
        end else begin
            wait_reg <= !(req && wait_reg && !halt_reg);
            if (rd_take) begin
                rdata_reg <= rd_word;
            end
        end
    end

    // state that must survive a system reset lives on power-on reset
    // operation outlives system reset
    always_ff @(posedge i_clk or posedge i_por) begin
        if (i_por) begin
            busy_flag_reg <= 1'b0;
            halt_reg      <= 1'b0;
            lock_reg      <= fsps_pkg::LOCK_RST;
        end else begin
            busy_flag_reg <= busy_flag_next;
            halt_reg      <= halt_next;
            if (op_done && (op_kind == fsps_pkg::OP_LOCK)) begin
                lock_reg[fsps_pkg::LOCK_LSB +: fsps_pkg::LOCK_W] <=
                    lock_reg[fsps_pkg::LOCK_LSB +: fsps_pkg::LOCK_W] & op_lock;
            end
        end
    end

    // buffer port and interrupt; buffer clear comes up high out of reset
    // buffer erased on reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_reg       <= 1'b0;
            buf_load_reg  <= 1'b0;
            buf_clear_reg <= 1'b1;
            word_reg      <= '0;
            data_reg      <= 16'h0000;
        end else begin
            irq_reg       <= irq_next;
            buf_load_reg  <= st_bload;
            buf_clear_reg <= clear_next;
            if (st_bload) begin
                word_reg <= ptr_word;
                data_reg <= dat_reg;
            end
        end
    end

    fsps_prog_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .i_clk   (i_clk),
        .i_por   (i_por),
        .i_start (st_long),
        .i_kind  (st_erase ? fsps_pkg::OP_ERASE : (st_write ? fsps_pkg::OP_WRITE : fsps_pkg::OP_LOCK)),
        .i_page  (ptr_page),
        .i_lock  (dat_reg[fsps_pkg::LOCK_LSB +: fsps_pkg::LOCK_W]),
        .o_busy  (op_busy),
        .o_done  (op_done),
        .o_erase (op_erase),
        .o_write (op_write),
        .o_kind  (op_kind),
        .o_page  (op_page),
        .o_lock  (op_lock)
    );

    // outputs, each a flop
    assign o_avs_waitrequest = wait_reg;
    assign o_avs_readdata    = rdata_reg;
    assign o_mem_addr        = ptr_reg;
    assign o_section_blocked = busy_flag_reg;
    assign o_cpu_halt        = halt_reg;
    assign o_irq             = irq_reg;
    assign o_flash           = '{erase: op_erase, write: op_write, buf_load: buf_load_reg,
                                 buf_clear: buf_clear_reg, page: op_page, word: word_reg, data: data_reg};
endmodule

/* File: bench/fsps_seq_assertions.sv */
// checker for the flash self-program sequencer: bus answer, operation timing, halt, flags
// bound onto the top ports; off while either reset is high unless a property says otherwise
`timescale 1ns/1ns
module fsps_seq_assertions #(
    parameter int unsigned                 PROG_CYCLES     = fsps_pkg::PROG_MIN_CYC,
    parameter logic [fsps_pkg::PAGE_W-1:0] HALT_FIRST_PAGE = 7'h60
) (
    input wire logic                  i_clk,
    input wire logic                  i_rst,
    input wire logic                  i_por,
    input wire logic                  i_avs_read,
    input wire logic                  i_avs_write,
    input wire logic                  o_avs_waitrequest,
    input wire fsps_pkg::fsps_flash_s o_flash,
    input wire logic                  o_section_blocked,
    input wire logic                  o_cpu_halt,
    input wire logic                  o_irq
);
    logic [31:0] cnt_reg;
    wire         op_on;
    // erase or write in progress
    assign op_on = o_flash.write | o_flash.erase;
    // run length of the operation, zero while none runs; of the two resets only power-on clears it, like the timer
    always_ff @(posedge i_clk or posedge i_por) begin
        if (i_por) begin
            cnt_reg <= 32'h0;
        end else begin
            cnt_reg <= op_on ? cnt_reg + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst || i_por);
    a_op_length: assert property ($fell(op_on) |-> cnt_reg == PROG_CYCLES)
        else $error("operation length differs from the programming time");
    a_reset_keeps_op: assert property (disable iff (i_por)
        op_on && cnt_reg < PROG_CYCLES - 1 |=> op_on) else $error("operation cut short");
    a_page_held: assert property (op_on && $past(op_on) |-> $stable(o_flash.page))
        else $error("page moved during operation");
    a_busy_flag_set: assert property (op_on && $past(op_on) && o_flash.page < HALT_FIRST_PAGE
        |-> o_section_blocked) else $error("section busy flag missing");
    a_halt_cause: assert property (o_cpu_halt |-> $past(op_on))
        else $error("halt without operation");
    a_halt_stalls: assert property (o_cpu_halt && $past(o_cpu_halt) |-> o_avs_waitrequest)
        else $error("access answered while halted");
    a_irq_quiet: assert property (op_on && $past(op_on) |-> !o_irq)
        else $error("interrupt while enable bit reads set");
    a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        && !o_cpu_halt && !op_on |-> ##[1:2] !o_avs_waitrequest) else $error("access not answered");
    a_buf_cleared: assert property ($fell(o_flash.write) |-> ##[0:2] o_flash.buf_clear)
        else $error("page buffer not cleared after write");
    c_blocked_write: cover property (o_flash.write && o_section_blocked);
    c_halted: cover property (o_cpu_halt);
    c_irq: cover property ($rose(o_irq));
endmodule

/* File: bench/fsps_flash_model.sv */
// program flash array as seen by the sequencer's load path
// answers combinationally for any address; contents are a fixed address hash
`timescale 1ns/1ns
module fsps_flash_model (
    input  wire logic [15:0] i_addr,
    output logic [7:0]       o_rdata
);
    // byte hashed from both address bytes so a wrong pointer shows
    assign o_rdata = i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A;
endmodule

/* File: bench/fsps_sequencer_bench.sv */
// self-checking bench: plays the core on the register bus against the sequencer
// assumes the flash model on the load path and a short programming time
`timescale 1ns/1ns
module fsps_sequencer_bench;
    localparam int unsigned PC = 20;
    logic clk = 1'b0, rst = 1'b1, por = 1'b1, rd = 1'b0, wr = 1'b0, ee = 1'b0, wrq, blk, halt, irq;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [15:0] maddr;
    logic [7:0] mdat;
    fsps_pkg::fsps_flash_s fl;
    logic [15:0] fp [3] = '{16'h0000, 16'h0003, 16'h0002};
    logic [7:0] fe [3] = '{8'h3C, 8'hD9, 8'hF6};
    int err_count = 0, n_compared = 0, cyc = 0;
    fsps_sequencer #(.PROG_CYCLES(PC), .FUSE_LOW(8'h3C), .FUSE_HIGH(8'hD9), .FUSE_EXT(4'h6)) u_fsps_sequencer (
        .i_clk(clk), .i_rst(rst), .i_por(por), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wrq),
        .i_eeprom_busy(ee), .i_mem_rdata(mdat), .o_mem_addr(maddr), .o_flash(fl),
        .o_section_blocked(blk), .o_cpu_halt(halt), .o_irq(irq));
    fsps_flash_model u_fsps_flash_model (.i_addr(maddr), .o_rdata(mdat));
    function automatic logic [7:0] mb(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    task automatic conclude;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s: expected %h seen %h", nm, e, s);
        end
    endtask
    // one bus access held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wrq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wt(input logic [4:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] e, input string nm);
        acc(1'b0, a, 32'h0);
        chk(q, e, nm);
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge clk);
    endtask
    // poll the enable bit until the operation is over
    task automatic wdone;
        do acc(1'b0, 5'h00, 32'h0); while (q[0] !== 1'b0);
    endtask
    initial begin
        forever #4 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            conclude;
        end
    end
    initial begin
        cy(5);
        rst <= 1'b0;
        por <= 1'b0;
        rc(5'h00, 32'h00, "ctrl reset");
        rc(5'h0C, 32'h0, "status idle");
        wt(5'h04, 32'h46);
        wt(5'h08, 32'hBEEF);
        wt(5'h00, 32'h01);
        wt(5'h0C, 32'h0);
        cy(1);
        chk({fl.buf_load, fl.word, fl.data}, 32'h23BEEF, "buffer load");
        rc(5'h00, 32'h00, "ctrl after store");
        wt(5'h04, 32'h140);
        wt(5'h00, 32'h85);
        wt(5'h0C, 32'h0);
        rc(5'h00, 32'hC5, "ctrl in write");
        wt(5'h04, 32'h40);
        rc(5'h10, 32'hFF, "blocked load");
        wt(5'h04, 32'h1802);
        rc(5'h10, mb(16'h1802), "halting load");
        chk(fl.page, 32'h05, "latched page");
        wdone;
        cy(2);
        chk(irq, 32'h1, "irq");
        rc(5'h00, 32'hC0, "ctrl after write");
        wt(5'h00, 32'h91);
        wt(5'h0C, 32'h0);
        rc(5'h00, 32'h80, "ctrl reenabled");
        wt(5'h04, 32'h40);
        rc(5'h10, mb(16'h40), "normal load");
        wt(5'h04, 32'h1800);
        wt(5'h00, 32'h05);
        wt(5'h0C, 32'h0);
        cy(3);
        chk(halt, 32'h1, "halt");
        rst <= 1'b1;
        cy(2);
        chk(fl.buf_clear, 32'h1, "buffer clear");
        rst <= 1'b0;
        chk(fl.write, 32'h1, "write kept");
        chk(blk, 32'h0, "busy flag");
        wdone;
        wt(5'h04, 32'h1);
        wt(5'h08, 32'hE3);
        wt(5'h00, 32'h09);
        wt(5'h0C, 32'h0);
        wt(5'h04, 32'h40);
        rc(5'h10, mb(16'h40), "load in lock op");
        wdone;
        wt(5'h04, 32'h1);
        wt(5'h00, 32'h09);
        rc(5'h10, 32'hE3, "lock bits");
        rc(5'h00, 32'h00, "ctrl after read");
        foreach (fp[i]) begin
            wt(5'h04, {16'h0, fp[i]});
            wt(5'h00, 32'h09);
            rc(5'h10, {24'h0, fe[i]}, "fuse");
        end
        wt(5'h04, 32'h1);
        wt(5'h00, 32'h09);
        cy(5);
        rc(5'h10, mb(16'h1), "late load");
        rc(5'h00, 32'h00, "lapsed ctrl");
        wt(5'h00, 32'h09);
        ee <= 1'b1;
        rc(5'h10, 32'hFF, "eeprom lock read");
        rc(5'h0C, 32'h4, "eeprom status");
        wt(5'h00, 32'h09);
        rc(5'h10, mb(16'h1), "refused lock read");
        wt(5'h04, 32'h80);
        wt(5'h00, 32'h05);
        wt(5'h0C, 32'h0);
        cy(2);
        chk(fl.write, 32'h0, "eeprom write");
        ee <= 1'b0;
        wt(5'h00, 32'h07);
        rc(5'h00, 32'h00, "bad pattern ctrl");
        wt(5'h0C, 32'h0);
        cy(2);
        chk(fl.write | fl.erase, 32'h0, "bad pattern");
        wt(5'h00, 32'h05);
        cy(6);
        wt(5'h0C, 32'h0);
        cy(2);
        chk(fl.write, 32'h0, "late store");
        wt(5'h04, 32'h1C0);
        wt(5'h00, 32'h03);
        wt(5'h0C, 32'h0);
        cy(2);
        chk({fl.erase, fl.page}, 32'h87, "erase");
        wdone;
        wt(5'h14, 32'hFFFF);
        rc(5'h14, 32'h0, "unmapped");
        conclude;
    end
endmodule
bind fsps_sequencer fsps_seq_assertions #(
    .PROG_CYCLES     (PROG_CYCLES),
    .HALT_FIRST_PAGE (HALT_FIRST_PAGE)
) u_chk (
    .i_clk             (i_clk),
    .i_rst             (i_rst),
    .i_por             (i_por),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .o_avs_waitrequest (o_avs_waitrequest),
    .o_flash           (o_flash),
    .o_section_blocked (o_section_blocked),
    .o_cpu_halt        (o_cpu_halt),
    .o_irq             (o_irq)
);
